// ===== logic/cell_pkg.sv
// Package: shared constants and carriers for the configurable logic cell
package cell_pkg;
  // ------------------------------------------------------------
  // Widths and counts
  // ------------------------------------------------------------
  localparam int unsigned NUM_INPUTS = 16;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned NUM_GATES = 4;
  localparam int unsigned NUM_CELLS = 4;
  // ------------------------------------------------------------
  // Control register fields and reset value
  // ------------------------------------------------------------
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned CTL_FALL_POS = 3;
  localparam int unsigned CTL_RISE_POS = 4;
  localparam int unsigned CTL_OUT_POS = 5;
  localparam int unsigned CTL_EN_POS = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // ------------------------------------------------------------
  // Logic function encodings
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_AND_OR  = 3'h0,
    FN_OR_XOR  = 3'h1,
    FN_AND4    = 3'h2,
    FN_SR      = 3'h3,
    FN_DFF_SR  = 3'h4,
    FN_DFF_R   = 3'h5,
    FN_JK_R    = 3'h6,
    FN_DLAT_SR = 3'h7
  } func_t;
  // ------------------------------------------------------------
  // Configuration carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_GATES-1:0][SEL_W-1:0] input_select_reg;
    logic [NUM_GATES-1:0][NUM_GATES*2-1:0] gate_source_reg;
    logic [NUM_GATES-1:0] gate_polarity_bits;
    logic output_polarity_bit;
  } cell_cfg_t;
endpackage : cell_pkg

// ===== logic/cell_function.sv
// Logic function that combines the four gate outputs
`timescale 1ns/1ps
module cell_function (
  // Clock
  input wire logic MCLK,
  input wire logic CE,
  input wire logic RST,
  // Function
  input wire logic [2:0] MODE,
  input wire logic [3:0] GATE,
  output logic RESULT
);
  import cell_pkg::*;
  logic store_q;
  logic store_d;
  logic comb_w;
  func_t fn;
  assign fn = func_t'(MODE);
  // ------------------------------------------------------------
  // Function table
  // ------------------------------------------------------------
  always_comb begin
    comb_w = 1'b0;
    store_d = store_q;
    unique case (fn)
      FN_AND_OR: comb_w = (GATE[0] & GATE[1]) | (GATE[2] & GATE[3]);
      FN_OR_XOR: comb_w = (GATE[0] | GATE[1]) ^ (GATE[2] | GATE[3]);
      FN_AND4: comb_w = &GATE;
      FN_SR: begin
        if (GATE[2] | GATE[3]) store_d = 1'b0;
        else if (GATE[0] | GATE[1]) store_d = 1'b1;
      end
      FN_DFF_SR: begin
        if (GATE[2]) store_d = 1'b0;
        else if (GATE[3]) store_d = 1'b1;
        else if (GATE[0]) store_d = GATE[1];
      end
      FN_DFF_R: begin
        if (GATE[2]) store_d = 1'b0;
        else if (GATE[0]) store_d = GATE[1] & GATE[3];
      end
      FN_JK_R: begin
        if (GATE[2]) store_d = 1'b0;
        else if (GATE[0]) store_d = (GATE[1] & ~store_q) | (~GATE[3] & store_q);
      end
      FN_DLAT_SR: begin
        if (GATE[2]) store_d = 1'b0;
        else if (GATE[3]) store_d = 1'b1;
        else if (GATE[0]) store_d = GATE[1];
      end
    endcase
  end
  // Sequential modes sample on the clock rather than on gate edges
  assign RESULT = (fn inside {FN_AND_OR, FN_OR_XOR, FN_AND4}) ? comb_w : store_q;
  always_ff @(posedge MCLK) begin
    if (RST) begin
      store_q <= 1'b0;
    end else if (CE) begin
      store_q <= store_d;
    end
  end
endmodule : cell_function

// ===== logic/logic_cell.sv
// Control, interrupt and status logic of one configurable logic cell
`timescale 1ns/1ps
module logic_cell #(
  parameter int unsigned OSC_INPUT = 0
) (
  // Clock, enable, reset
  input wire logic MCLK,
  input wire logic CE,
  input wire logic RST,
  // Sleep indication
  input wire logic SLEEP,
  // Data inputs from pins and peripherals
  input wire logic [cell_pkg::NUM_INPUTS-1:0] DATA_IN,
  // Configuration write strobes
  input wire logic CTL_WR,
  input wire logic [7:0] CTL_WDATA,
  input wire logic CFG_WR,
  input wire cell_pkg::cell_cfg_t CFG_WDATA,
  // Interrupt handling
  input wire logic FLAG_CLR,
  input wire logic CELL_IRQ_ENABLE,
  input wire logic PERIPHERAL_IRQ_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  // Other cells outputs for the mirror
  input wire logic [cell_pkg::NUM_CELLS-2:0] OTHER_OUT,
  // Status
  output logic [7:0] CELL_CONTROL_REG,
  output cell_pkg::cell_cfg_t CFG_RDATA,
  output logic CELL_IRQ_FLAG,
  output logic CPU_IRQ,
  output logic CELL_OUTPUT_BIT,
  output logic [cell_pkg::NUM_CELLS-1:0] OUTPUT_MIRROR_REG,
  output logic FAST_OSC_KEEP
);
  import cell_pkg::*;
  // ------------------------------------------------------------
  // Synchronisers for outside inputs
  // ------------------------------------------------------------
  logic [NUM_INPUTS-1:0] in_s1_q;
  logic [NUM_INPUTS-1:0] in_s2_q;
  logic [NUM_CELLS-2:0] oth_s1_q;
  logic [NUM_CELLS-2:0] oth_s2_q;
  always_ff @(posedge MCLK) begin
    if (CE) begin
      in_s1_q <= DATA_IN;
      in_s2_q <= in_s1_q;
      oth_s1_q <= OTHER_OUT;
      oth_s2_q <= oth_s1_q;
    end
  end
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] ctl_q;
  cell_cfg_t cfg_q;
  logic flag_q;
  logic flag_d;
  logic out_prev_q;
  logic [NUM_CELLS-1:0] mirror_q;
  logic out_q;
  wire cell_en = ctl_q[CTL_EN_POS];
  wire rise_irq_enable = ctl_q[CTL_RISE_POS];
  wire fall_irq_enable = ctl_q[CTL_FALL_POS];
  wire [2:0] logic_function_field = ctl_q[CTL_MODE_LSB +: 3];
  // Only reset clears control; configuration keeps its value
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ctl_q <= CTL_RESET;
    end else if (CE && CTL_WR) begin
      ctl_q <= CTL_WDATA;
    end
  end
  always_ff @(posedge MCLK) begin
    if (CE && CFG_WR) begin
      cfg_q <= CFG_WDATA;
    end
  end
  // ------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------
  logic [NUM_GATES-1:0] chosen;
  logic [NUM_GATES-1:0] gate_w;
  logic func_out;
  logic cell_out;
  genvar g;
  generate
    for (g = 0; g < NUM_GATES; g++) begin : gen_gate
      assign chosen[g] = in_s2_q[cfg_q.input_select_reg[g]];
      // Each chosen input enters true and inverted: bit 2k true, 2k+1 inverted
      wire [NUM_GATES*2-1:0] terms = {~chosen[3], chosen[3], ~chosen[2], chosen[2],
                                      ~chosen[1], chosen[1], ~chosen[0], chosen[0]};
      assign gate_w[g] = (|(terms & cfg_q.gate_source_reg[g]))
                         ^ cfg_q.gate_polarity_bits[g];
    end
  endgenerate
  cell_function u_fn (
    .MCLK(MCLK),
    .CE(CE),
    .RST(RST),
    .MODE(logic_function_field),
    .GATE(gate_w),
    .RESULT(func_out)
  );
  // Datapath runs without gating by SLEEP, so Sleep does not stop it
  assign cell_out = cell_en & (func_out ^ cfg_q.output_polarity_bit);
  // ------------------------------------------------------------
  // Edge detection and flag
  // ------------------------------------------------------------
  wire rise_ev = cell_en & out_q & ~out_prev_q;
  wire fall_ev = cell_en & ~out_q & out_prev_q;
  wire set_ev = (rise_ev & rise_irq_enable) | (fall_ev & fall_irq_enable);
  // Set beats clear
  assign flag_d = set_ev | (flag_q & ~FLAG_CLR);
  always_ff @(posedge MCLK) begin
    if (RST) begin
      out_q <= 1'b0;
      out_prev_q <= 1'b0;
      flag_q <= 1'b0;
      mirror_q <= '0;
    end else if (CE) begin
      out_q <= cell_out;
      out_prev_q <= out_q;
      flag_q <= flag_d;
      mirror_q <= {oth_s2_q, cell_out};
    end
  end
  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign CELL_CONTROL_REG = {ctl_q[7:6], out_q, ctl_q[4:0]};
  assign CFG_RDATA = cfg_q;
  assign CELL_IRQ_FLAG = flag_q;
  assign CELL_OUTPUT_BIT = out_q;
  assign OUTPUT_MIRROR_REG = mirror_q;
  assign CPU_IRQ = flag_q & CELL_IRQ_ENABLE & PERIPHERAL_IRQ_ENABLE
                   & GLOBAL_IRQ_ENABLE & cell_en;
  wire osc_sel = (cfg_q.input_select_reg[0] == SEL_W'(OSC_INPUT))
               | (cfg_q.input_select_reg[1] == SEL_W'(OSC_INPUT))
               | (cfg_q.input_select_reg[2] == SEL_W'(OSC_INPUT))
               | (cfg_q.input_select_reg[3] == SEL_W'(OSC_INPUT));
  assign FAST_OSC_KEEP = SLEEP & cell_en & osc_sel;
endmodule : logic_cell

// ===== test/logic_cell_props.sv
// Checker for the logic cell
`timescale 1ns/1ps
module logic_cell_props (
  // Clock and reset
  input wire logic MCLK,
  input wire logic CE,
  input wire logic RST,
  // Watched ports
  input wire logic FLAG_CLR,
  input wire logic CELL_IRQ_ENABLE,
  input wire logic PERIPHERAL_IRQ_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic [7:0] CELL_CONTROL_REG,
  input wire logic CELL_IRQ_FLAG,
  input wire logic CPU_IRQ,
  input wire logic CELL_OUTPUT_BIT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  wire logic [7:0] ctl = CELL_CONTROL_REG;
  // Edges only count while enabled and not swallowed by a reset on the setting edge
  a_rise_flag:
    assert property (CE && !RST && ctl[7] && $rose(CELL_OUTPUT_BIT) && ctl[4]
      |=> CELL_IRQ_FLAG) else $error("rise");
  a_fall_flag:
    assert property (CE && !RST && ctl[7] && $fell(CELL_OUTPUT_BIT) && ctl[3]
      |=> CELL_IRQ_FLAG) else $error("fall");
  a_flag_cause:
    assert property ($rose(CELL_IRQ_FLAG) |-> $past(CELL_OUTPUT_BIT) != $past(CELL_OUTPUT_BIT, 2))
    else $error("flag without edge");
  a_flag_sticky:
    assert property (CELL_IRQ_FLAG && !FLAG_CLR |=> CELL_IRQ_FLAG) else $error("flag lost");
  a_set_wins:
    assert property (CE && !RST && ctl[7] && $rose(CELL_OUTPUT_BIT) && ctl[4] && FLAG_CLR
      |=> CELL_IRQ_FLAG) else $error("clear beat set");
  a_cpu_gate:
    assert property (CPU_IRQ == (CELL_IRQ_FLAG && CELL_IRQ_ENABLE && PERIPHERAL_IRQ_ENABLE
      && GLOBAL_IRQ_ENABLE && ctl[7])) else $error("cpu irq");
  a_out_copy:
    assert property (ctl[5] == CELL_OUTPUT_BIT) else $error("output copy");
  a_ctl_reset:
    assert property (disable iff (1'b0) RST && CE |=> ctl == 8'h00) else $error("ctl reset");
  a_off_low:
    assert property (!ctl[7] [*2] |-> !CELL_OUTPUT_BIT) else $error("off not low");
  c_rise: cover property ($rose(CELL_IRQ_FLAG));
  c_race: cover property (FLAG_CLR && $rose(CELL_OUTPUT_BIT));
  c_irq: cover property (CPU_IRQ);
endmodule : logic_cell_props
bind logic_cell logic_cell_props u_props (.MCLK(MCLK), .CE(CE), .RST(RST), .FLAG_CLR(FLAG_CLR),
  .CELL_IRQ_ENABLE(CELL_IRQ_ENABLE), .PERIPHERAL_IRQ_ENABLE(PERIPHERAL_IRQ_ENABLE),
  .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .CELL_CONTROL_REG(CELL_CONTROL_REG),
  .CELL_IRQ_FLAG(CELL_IRQ_FLAG), .CPU_IRQ(CPU_IRQ), .CELL_OUTPUT_BIT(CELL_OUTPUT_BIT));

// ===== test/tb.sv
// Self-checking bench for the logic cell
`timescale 1ns/1ps
module tb;
  import cell_pkg::*;
  logic mclk = 0, rst = 1, sleep = 0, ctl_wr = 0, cfg_wr = 0, flag_clr = 0;
  logic cie = 0, irq_enable_regs = 0, global_irq_enable = 0, flag, cpu_irq, cell_out, osc_keep;
  logic [15:0] data_in = 16'h0000;
  logic [7:0] ctl_wdata = 8'h00, ctl_rd;
  logic [2:0] other_out = 3'h0;
  logic [3:0] mirror;
  cell_cfg_t cfg_wdata = '0, cfg_rd;
  int bad_count = 0, cmp_count = 0;
  logic_cell u_dut (.MCLK(mclk), .CE(1'b1), .RST(rst), .SLEEP(sleep), .DATA_IN(data_in),
    .CTL_WR(ctl_wr), .CTL_WDATA(ctl_wdata), .CFG_WR(cfg_wr), .CFG_WDATA(cfg_wdata),
    .FLAG_CLR(flag_clr), .CELL_IRQ_ENABLE(cie), .PERIPHERAL_IRQ_ENABLE(irq_enable_regs),
    .GLOBAL_IRQ_ENABLE(global_irq_enable), .OTHER_OUT(other_out), .CELL_CONTROL_REG(ctl_rd),
    .CFG_RDATA(cfg_rd), .CELL_IRQ_FLAG(flag), .CPU_IRQ(cpu_irq), .CELL_OUTPUT_BIT(cell_out),
    .OUTPUT_MIRROR_REG(mirror), .FAST_OSC_KEEP(osc_keep));
  initial forever #10 mclk = ~mclk;
  // ----
  // Access tasks
  // ----
  task cyc(input int n); repeat (n) @(posedge mclk); endtask : cyc
  task ctl(input logic [7:0] v);
    @(posedge mclk); ctl_wr <= 1; ctl_wdata <= v; @(posedge mclk); ctl_wr <= 0;
  endtask : ctl
  task cfg(input cell_cfg_t v);
    @(posedge mclk); cfg_wr <= 1; cfg_wdata <= v; @(posedge mclk); cfg_wr <= 0;
  endtask : cfg
  task setd(input logic b); @(posedge mclk); data_in[5] <= b; cyc(5); @(negedge mclk); endtask : setd
  task clr; @(posedge mclk); flag_clr <= 1; @(posedge mclk); flag_clr <= 0; endtask : clr
  task chk(input string name, input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Inverted lanes with inverted gates must give the plain input back
  function automatic cell_cfg_t mk(input logic [3:0] sel, input logic gp, po);
    cell_cfg_t c;
    c.input_select_reg = {4{sel}};
    c.gate_source_reg = {4{gp ? 8'h02 : 8'h01}};
    c.gate_polarity_bits = {4{gp}};
    c.output_polarity_bit = po;
    return c;
  endfunction : mk
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Tests take about 120 cycles
  initial begin #60000; bad_count++; test_done; end
  initial begin
    cyc(5); rst <= 0; cie <= 1; irq_enable_regs <= 1; global_irq_enable <= 1;
    @(negedge mclk); chk("ctl", ctl_rd, 8'h00);
    chk("flag", flag, 0);
    cfg(mk(4'h5, 0, 0)); ctl(8'h92); setd(1);
    chk("out", cell_out, 1);
    chk("flag", flag, 1);
    chk("cpu", cpu_irq, 1);
    @(posedge mclk); other_out <= 3'h5; global_irq_enable <= 0; cyc(10); @(negedge mclk);
    chk("mirror", mirror, 4'hB);
    chk("cpu", cpu_irq, 0);
    chk("flag", flag, 1);
    $display("test rise done");
    clr; setd(0); chk("flag", flag, 0);
    ctl(8'h8A); setd(1); chk("flag", flag, 0);
    setd(0); chk("flag", flag, 1);
    chk("mirror", mirror, 4'hA);
    ctl(8'h9A); @(posedge mclk); flag_clr <= 1; data_in[5] <= 1;
    for (int n = 0; n < 9 && cell_out !== 1; n++) @(negedge mclk);
    @(posedge mclk); flag_clr <= 0; @(negedge mclk);
    chk("flag", flag, 1);
    $display("test edges done");
    ctl(8'h00); cfg(mk(4'h5, 1, 1)); ctl(8'h82); cyc(5); @(negedge mclk);
    chk("out", cell_out, 0);
    setd(0); chk("out", cell_out, 1);
    clr; ctl(8'h1A); cyc(5); @(negedge mclk);
    chk("out", cell_out, 0);
    chk("flag", flag, 0);
    $display("test polarity done");
    ctl(8'h92); @(posedge mclk); rst <= 1; @(posedge mclk); rst <= 0; @(negedge mclk);
    chk("ctl", ctl_rd, 8'h00);
    chk("cfg", cfg_rd, mk(4'h5, 1, 1));
    $display("test reset done");
    cfg(mk(4'h0, 0, 0)); ctl(8'h82); @(posedge mclk); sleep <= 1; data_in[0] <= 1;
    cyc(5); @(negedge mclk);
    chk("osc", osc_keep, 1);
    chk("out", cell_out, 1);
    @(posedge mclk); sleep <= 0; @(negedge mclk);
    chk("osc", osc_keep, 0);
    $display("test sleep done");
    // All gates equal: the or-xor function gives 0, the and-or function gives 1
    ctl(8'h00); cfg(mk(4'h5, 0, 0)); ctl(8'h81); setd(1);
    chk("out", cell_out, 0);
    ctl(8'h80); cyc(3); @(negedge mclk);
    chk("out", cell_out, 1);
    $display("test function done");
    test_done;
  end
endmodule : tb
